// ==== src/encoder_feature_control.sv ====
// Purpose: encoder feature word, frame scheduler and frame hand-off
// Assumes: pins synchronous to CLK_I; host packets already parsed
// Notes: word travels with each frame's sample count to the encoder
//
// Function
// - Sample config pins for interface and mode
// - Schedule encoder and decoder calls
// - Flag frames outside 156 to 164 samples
// - Hand 16-bit word with each frame
// - Word settings override configuration pins
// - Bit 6 runs noise suppressor
// - Bit 7 picks mu or A law
// - Bit 8 enables companding else linear
// - Bit 9 enables echo suppressor
// - Bit 11 enables silence frames
// - Bit 12 tone detect, resets to one
// - Bit 13 enables echo canceller
// - Bit 14 sends tone frame instead
// - Bit 14 resets to zero
// - Config packet loads all writable bits
// - Frame packet word applies that frame
// - Word holds until host changes it
`include "enc_word_defs.svh"
`default_nettype none
module encoder_feature_control #(
  parameter int FRAME_CYCLES = `FRAME_CYCLES
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic [1:0] IFACE_SEL_PIN_I,
  input wire logic [1:0] MODE_SEL_PIN_I,
  input wire logic NOISE_SUPPRESS_ON_PIN_I,
  input wire logic COMPAND_LAW_CHOICE_PIN_I,
  input wire logic COMPAND_ON_PIN_I,
  input wire logic ECHO_SUPPRESS_ON_PIN_I,
  input wire logic SILENCE_FRAME_ON_PIN_I,
  input wire logic ECHO_CANCEL_ON_PIN_I,
  input wire logic CFG_WORD_VALID_I,
  input wire logic FRAME_WORD_VALID_I,
  input wire enc_word_pkg::feature_word_t ENCODER_WORD_PACKET_FIELD_I,
  input wire logic SAMPLE_VALID_I,
  input wire logic FRAME_END_I,
  output logic SAMPLE_READY_O,
  output logic ENC_CALL_VALID_O,
  input wire logic ENC_CALL_READY_I,
  output enc_word_pkg::feature_word_t ENC_WORD_O,
  output logic [8:0] ENC_SAMPLE_COUNT_O,
  output logic ENC_SIZE_ERR_O,
  output logic DEC_CALL_O,
  output logic RUNNING_O,
  output logic [1:0] IFACE_SEL_O,
  output logic [1:0] MODE_SEL_O,
  output enc_word_pkg::feature_word_t ENCODER_WORD_O,
  output logic NOISE_SUPPRESS_ON_O,
  output logic COMPAND_ON_O,
  output logic COMPAND_LAW_CHOICE_O,
  output logic ECHO_SUPPRESS_ON_O,
  output logic SILENCE_FRAME_ON_O,
  output logic TONE_DETECT_ON_O,
  output logic ECHO_CANCEL_ON_O,
  output logic TONE_SEND_ON_O
);
  import enc_word_pkg::*;

  localparam int TW = $clog2(FRAME_CYCLES + 1);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    phase_t phase;
    logic [1:0] iface;
    logic [1:0] mode;
    feature_word_t word;
    logic [8:0] count;
    logic [TW-1:0] timer;
    logic dec_call;
    logic size_err;
    logic [8:0] out_count;
  } ctl_state_t;

  ctl_state_t s_reg;
  ctl_state_t s_next;

  logic buf_in_valid;
  logic buf_in_ready;
  logic [24:0] buf_out_data;
  logic frame_close;
  feature_word_t frame_word;

  // Keeps only documented feature bits; reserved positions stay zero
  function automatic feature_word_t clean_word(input feature_word_t w);
    clean_word = w & `WORD_WRITABLE_MASK;
  endfunction : clean_word

  // Builds the post-reset word from pins
  function automatic feature_word_t strap_word(
    input logic ns, input logic law, input logic cp,
    input logic es, input logic dtx, input logic ec);
    feature_word_t w;
    w = `WORD_RESET_FIXED;
    w[`BIT_NOISE_SUPPRESS] = ns;
    w[`BIT_COMPAND_LAW] = law;
    w[`BIT_COMPAND_ON] = cp;
    w[`BIT_ECHO_SUPPRESS] = es;
    w[`BIT_SILENCE_FRAME] = dtx;
    w[`BIT_ECHO_CANCEL] = ec;
    strap_word = w;
  endfunction : strap_word

  // ----------------------------------------------------------------
  // Frame word selection
  // ----------------------------------------------------------------
  // A word arriving with the closing frame packet applies to that frame
  always_comb begin
    if (FRAME_WORD_VALID_I) begin
      frame_word = clean_word(ENCODER_WORD_PACKET_FIELD_I);
    end else begin
      frame_word = s_reg.word;
    end
  end

  assign frame_close = (s_reg.phase == ST_RUN) && FRAME_END_I;
  assign buf_in_valid = frame_close;
  // Stall intake while a closed frame cannot be queued
  assign SAMPLE_READY_O = (s_reg.phase == ST_RUN) && buf_in_ready;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.dec_call = 1'b0;
    case (s_reg.phase)
      ST_RESET: begin
        s_next.phase = ST_STRAP;
      end
      ST_STRAP: begin
        // Pins caught on the second clock edge after release, never under reset
        s_next.iface = IFACE_SEL_PIN_I;
        s_next.mode = MODE_SEL_PIN_I;
        s_next.word = strap_word(NOISE_SUPPRESS_ON_PIN_I,
          COMPAND_LAW_CHOICE_PIN_I, COMPAND_ON_PIN_I,
          ECHO_SUPPRESS_ON_PIN_I, SILENCE_FRAME_ON_PIN_I,
          ECHO_CANCEL_ON_PIN_I);
        s_next.phase = ST_RUN;
      end
      ST_RUN: begin
        if (CFG_WORD_VALID_I) begin
          s_next.word = clean_word(ENCODER_WORD_PACKET_FIELD_I);
        end
        if (FRAME_WORD_VALID_I) begin
          s_next.word = clean_word(ENCODER_WORD_PACKET_FIELD_I);
        end
        if (SAMPLE_VALID_I && SAMPLE_READY_O && s_reg.count != 9'h1FF) begin
          s_next.count = s_reg.count + 9'd1;
        end
        if (frame_close && buf_in_ready) begin
          s_next.count = '0;
          s_next.out_count = s_reg.count;
          s_next.size_err = (s_reg.count < `SAMPLES_MIN) ||
            (s_reg.count > `SAMPLES_MAX);
        end
        // Decoder called on the frame cadence
        if (s_reg.timer == TW'(FRAME_CYCLES - 1)) begin
          s_next.timer = '0;
          s_next.dec_call = 1'b1;
        end else begin
          s_next.timer = s_reg.timer + TW'(1);
        end
      end
      default: begin
        s_next.phase = ST_RESET;
      end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      s_reg <= '0;
      s_reg.phase <= ST_RESET;
      s_reg.word <= `WORD_RESET_FIXED;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Frame hand-off
  // ----------------------------------------------------------------
  // Word and sample count leave together; up to two frames wait for a stalled encoder
  frame_buf2 #(
    .WIDTH(25)
  ) u_frame_buf (
    .CLK_I(CLK_I),
    .RST_I(RST_I),
    .in_valid_i(buf_in_valid),
    .in_ready_o(buf_in_ready),
    .in_data_i({frame_word, s_reg.count}),
    .out_valid_o(ENC_CALL_VALID_O),
    .out_ready_i(ENC_CALL_READY_I),
    .out_data_o(buf_out_data)
  );

  assign ENC_WORD_O = buf_out_data[24:9];
  assign ENC_SAMPLE_COUNT_O = buf_out_data[8:0];
  assign ENC_SIZE_ERR_O = s_reg.size_err;
  assign DEC_CALL_O = s_reg.dec_call;
  assign RUNNING_O = (s_reg.phase == ST_RUN);
  assign IFACE_SEL_O = s_reg.iface;
  assign MODE_SEL_O = s_reg.mode;
  assign ENCODER_WORD_O = s_reg.word;

  // ----------------------------------------------------------------
  // Feature enables
  // ----------------------------------------------------------------
  // Enables follow the word only; pins matter only at strap time
  assign NOISE_SUPPRESS_ON_O = s_reg.word[`BIT_NOISE_SUPPRESS];
  assign COMPAND_ON_O = s_reg.word[`BIT_COMPAND_ON];
  assign COMPAND_LAW_CHOICE_O = s_reg.word[`BIT_COMPAND_ON] &
    s_reg.word[`BIT_COMPAND_LAW];
  assign ECHO_SUPPRESS_ON_O = s_reg.word[`BIT_ECHO_SUPPRESS];
  assign SILENCE_FRAME_ON_O = s_reg.word[`BIT_SILENCE_FRAME];
  assign TONE_DETECT_ON_O = s_reg.word[`BIT_TONE_DETECT];
  assign ECHO_CANCEL_ON_O = s_reg.word[`BIT_ECHO_CANCEL];
  assign TONE_SEND_ON_O = s_reg.word[`BIT_TONE_SEND];
endmodule : encoder_feature_control
`default_nettype wire

// ==== src/enc_word_defs.svh ====
// Purpose: constants for the encoder feature word block
// Assumes: 50 MHz clock
// Notes: bit positions and reset values of the feature word
`ifndef ENC_WORD_DEFS_SVH
`define ENC_WORD_DEFS_SVH
`define CLK_PERIOD_NS 20
`define FRAME_TIME_MS 20
`define FRAME_CYCLES ((`FRAME_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`define SAMPLES_NOMINAL 9'd160
`define SAMPLES_MIN 9'd156
`define SAMPLES_MAX 9'd164
`define BIT_NOISE_SUPPRESS 6
`define BIT_COMPAND_LAW 7
`define BIT_COMPAND_ON 8
`define BIT_ECHO_SUPPRESS 9
`define BIT_SILENCE_FRAME 11
`define BIT_TONE_DETECT 12
`define BIT_ECHO_CANCEL 13
`define BIT_TONE_SEND 14
`define WORD_WRITABLE_MASK 16'h7BC0
`define WORD_RESET_FIXED 16'h1000
`endif

// ==== src/enc_word_pkg.sv ====
// Purpose: types for the encoder feature word block
// Assumes: nothing
// Notes: holds types only
`default_nettype none
package enc_word_pkg;
  typedef enum logic [1:0] {ST_RESET, ST_STRAP, ST_RUN} phase_t;
  typedef logic [15:0] feature_word_t;
  typedef struct packed {
    logic [15:0] data;
    logic compand_on;
    logic compand_law_choice;
  } frame_item_t;
endpackage : enc_word_pkg
`default_nettype wire

// ==== src/frame_buf2.sv ====
// Purpose: two-entry valid/ready buffer
// Assumes: synchronous active-high reset
// Notes: full throughput, no combinational ready path from output side
`default_nettype none
module frame_buf2 #(
  parameter int WIDTH = 16
) (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic [1:0] count;
    logic rd;
    logic wr;
  } buf_state_t;
  buf_state_t s_reg;
  buf_state_t s_next;
  logic push;
  logic pop;
  assign in_ready_o = (s_reg.count != 2'd2);
  assign out_valid_o = (s_reg.count != 2'd0);
  assign out_data_o = s_reg.mem[s_reg.rd];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.mem[s_reg.wr] = in_data_i;
      s_next.wr = ~s_reg.wr;
    end
    if (pop) begin
      s_next.rd = ~s_reg.rd;
    end
    case ({push, pop})
      2'b10: s_next.count = s_reg.count + 2'd1;
      2'b01: s_next.count = s_reg.count - 2'd1;
      default: s_next.count = s_reg.count;
    endcase
  end
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule : frame_buf2
`default_nettype wire

// ==== sim/encoder_feature_control_checker.sv ====
// Purpose: concurrent checks on the encoder feature word block
// Assumes: bound to encoder_feature_control, one clock domain
// Notes: sees only top-level ports
`default_nettype none
module efc_checker (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic CFG_WORD_VALID_I,
  input wire logic FRAME_WORD_VALID_I,
  input wire enc_word_pkg::feature_word_t ENCODER_WORD_PACKET_FIELD_I,
  input wire logic FRAME_END_I,
  input wire logic SAMPLE_READY_O,
  input wire logic ENC_CALL_VALID_O,
  input wire logic ENC_CALL_READY_I,
  input wire enc_word_pkg::feature_word_t ENC_WORD_O,
  input wire logic RUNNING_O,
  input wire enc_word_pkg::feature_word_t ENCODER_WORD_O,
  input wire logic COMPAND_LAW_CHOICE_O,
  input wire logic TONE_DETECT_ON_O,
  input wire logic TONE_SEND_ON_O
);
  import enc_word_pkg::*;
  // ---
  // Properties
  // ---
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  logic word_wr;
  assign word_wr = RUNNING_O && (CFG_WORD_VALID_I || FRAME_WORD_VALID_I);
  a_reset_word: assert property (
    $fell(RST_I) |-> ENCODER_WORD_O == 16'h1000)
    else $error("word not at reset value");
  a_reserved_zero: assert property (
    (ENCODER_WORD_O & 16'h843F) == 16'h0000)
    else $error("reserved word bit set");
  a_word_load: assert property (
    word_wr |=> ENCODER_WORD_O ==
      ($past(ENCODER_WORD_PACKET_FIELD_I) & 16'h7BC0))
    else $error("word not loaded");
  a_word_hold: assert property (
    RUNNING_O && !word_wr |=> $stable(ENCODER_WORD_O))
    else $error("word changed by itself");
  a_law_gate: assert property (
    COMPAND_LAW_CHOICE_O == (ENCODER_WORD_O[7] & ENCODER_WORD_O[8]))
    else $error("law select not gated");
  a_tone_bits: assert property (
    {TONE_SEND_ON_O, TONE_DETECT_ON_O} ==
      {ENCODER_WORD_O[14], ENCODER_WORD_O[12]})
    else $error("tone enables differ from word");
  a_call_issue: assert property (
    RUNNING_O && FRAME_END_I && SAMPLE_READY_O |=> ENC_CALL_VALID_O)
    else $error("no encoder call after frame close");
  a_call_stand: assert property (
    ENC_CALL_VALID_O && !ENC_CALL_READY_I |=>
      ENC_CALL_VALID_O && $stable(ENC_WORD_O))
    else $error("encoder call dropped early");
endmodule : efc_checker
bind encoder_feature_control efc_checker efc_checker_i (.*);
`default_nettype wire

// ==== sim/enc_host_model.sv ====
// Purpose: host model sending word and frame packets
// Assumes: drives 1 ns after the rising edge
// Notes: idle field shows the inverse of the last word
`default_nettype none
module enc_host_model (
  input wire logic CLK_I,
  output logic CFG_WORD_VALID_I,
  output logic FRAME_WORD_VALID_I,
  output enc_word_pkg::feature_word_t ENCODER_WORD_PACKET_FIELD_I,
  output logic SAMPLE_VALID_I,
  output logic FRAME_END_I
);
  timeunit 1ns;
  timeprecision 1ns;
  import enc_word_pkg::*;
  initial begin
    {CFG_WORD_VALID_I, FRAME_WORD_VALID_I} = 2'h0;
    {SAMPLE_VALID_I, FRAME_END_I} = 2'h0;
    ENCODER_WORD_PACKET_FIELD_I = 16'h0000;
  end
  // n samples, then a config word (c) or a frame close with optional word
  task automatic pkt(input int n, input logic c, input logic f,
                     input feature_word_t w);
    repeat (n) begin
      @(posedge CLK_I);
      #1 SAMPLE_VALID_I = 1'b1;
    end
    @(posedge CLK_I);
    #1 SAMPLE_VALID_I = 1'b0;
    CFG_WORD_VALID_I = c;
    FRAME_END_I = !c;
    FRAME_WORD_VALID_I = f;
    ENCODER_WORD_PACKET_FIELD_I = w;
    @(posedge CLK_I);
    #1 {CFG_WORD_VALID_I, FRAME_WORD_VALID_I, FRAME_END_I} = 3'h0;
    ENCODER_WORD_PACKET_FIELD_I = ~w;
  endtask : pkt
endmodule : enc_host_model
`default_nettype wire

// ==== sim/encoder_feature_control_tb.sv ====
// Purpose: self-checking bench for the encoder feature word block
// Assumes: frame period shortened to 50 cycles
// Notes: queue model of the two-entry call buffer
`default_nettype none
module encoder_feature_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import enc_word_pkg::*;
  logic CLK_I = 1'b0, RST_I = 1'b1, ENC_CALL_READY_I = 1'b0;
  logic [1:0] IFACE_SEL_PIN_I, MODE_SEL_PIN_I, IFACE_SEL_O, MODE_SEL_O;
  logic NOISE_SUPPRESS_ON_PIN_I, COMPAND_LAW_CHOICE_PIN_I, COMPAND_ON_PIN_I;
  logic ECHO_SUPPRESS_ON_PIN_I, SILENCE_FRAME_ON_PIN_I, ECHO_CANCEL_ON_PIN_I;
  logic CFG_WORD_VALID_I, FRAME_WORD_VALID_I, SAMPLE_VALID_I, FRAME_END_I;
  logic SAMPLE_READY_O, ENC_CALL_VALID_O, ENC_SIZE_ERR_O, DEC_CALL_O;
  logic RUNNING_O, NOISE_SUPPRESS_ON_O, COMPAND_ON_O, COMPAND_LAW_CHOICE_O;
  logic ECHO_SUPPRESS_ON_O, SILENCE_FRAME_ON_O, TONE_DETECT_ON_O;
  logic ECHO_CANCEL_ON_O, TONE_SEND_ON_O;
  logic [8:0] ENC_SAMPLE_COUNT_O;
  feature_word_t ENCODER_WORD_PACKET_FIELD_I, ENC_WORD_O, ENCODER_WORD_O;
  feature_word_t w_exp;
  logic [3:0] strap_exp;
  logic [31:0] seed = 32'hDE992911;
  int bad_count = 0, num_checks = 0, cyc = 0, last_dec = 0, acc = 0;
  int qc[$];
  feature_word_t qw[$];
  int sizes[6] = '{155, 156, 164, 165, 160, 158};
  always #10 CLK_I = ~CLK_I;
  encoder_feature_control #(.FRAME_CYCLES(50)) encoder_feature_control_i (.*);
  enc_host_model enc_host_model_i (.*);
  // ---
  // Tasks
  // ---
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input string s, input logic [15:0] e,
                     input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic stop_test();
    if (bad_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test
  task automatic chk_word(input feature_word_t w);
    chk("word", w, ENCODER_WORD_O);
    chk("flags", {w[14:11], w[9:8], w[7] & w[8], w[6]},
        {TONE_SEND_ON_O, ECHO_CANCEL_ON_O, TONE_DETECT_ON_O,
         SILENCE_FRAME_ON_O, ECHO_SUPPRESS_ON_O, COMPAND_ON_O,
         COMPAND_LAW_CHOICE_O,
         NOISE_SUPPRESS_ON_O});
  endtask : chk_word
  // Refused closes keep the count; samples sent while full are lost
  task automatic frame(input int n, input logic f);
    feature_word_t w;
    w = rnd();
    enc_host_model_i.pkt(n, 1'b0, f, w);
    if (f) w_exp = w & 16'h7BC0;
    if (qw.size() < 2) begin
      qw.push_back(w_exp);
      qc.push_back(acc + n);
      chk("size_err", (acc + n < 156) || (acc + n > 164), ENC_SIZE_ERR_O);
      acc = 0;
    end
  endtask : frame
  task automatic drain();
    int k;
    while (qw.size() > 0) begin
      for (k = 0; k < 20 && ENC_CALL_VALID_O !== 1'b1; k++) begin
        @(posedge CLK_I);
        #1;
      end
      chk("call", 1, ENC_CALL_VALID_O);
      chk("enc_word", qw.pop_front(), ENC_WORD_O);
      chk("count", qc.pop_front(), ENC_SAMPLE_COUNT_O);
      // Held across back-to-back pops so it never toggles in one step
      ENC_CALL_READY_I = 1'b1;
      @(posedge CLK_I);
      #1;
    end
    ENC_CALL_READY_I = 1'b0;
  endtask : drain
  // Pulse read mid-cycle, away from the edge that launches it
  always @(negedge CLK_I) begin
    cyc++;
    if (DEC_CALL_O === 1'b1) begin
      if (last_dec > 0) chk("dec_gap", 50, cyc - last_dec);
      last_dec = cyc;
    end
    if (cyc == 20000) begin
      bad_count++;
      stop_test();
    end
  end
  initial begin
    {IFACE_SEL_PIN_I, MODE_SEL_PIN_I, NOISE_SUPPRESS_ON_PIN_I,
     COMPAND_LAW_CHOICE_PIN_I, COMPAND_ON_PIN_I, ECHO_SUPPRESS_ON_PIN_I,
     SILENCE_FRAME_ON_PIN_I, ECHO_CANCEL_ON_PIN_I} = rnd();
    w_exp = {2'b00, ECHO_CANCEL_ON_PIN_I, 1'b1, SILENCE_FRAME_ON_PIN_I, 1'b0,
             ECHO_SUPPRESS_ON_PIN_I, COMPAND_ON_PIN_I, COMPAND_LAW_CHOICE_PIN_I,
             NOISE_SUPPRESS_ON_PIN_I, 6'h00};
    repeat (20) @(posedge CLK_I);
    #1 chk("rst_word", 16'h1000, ENCODER_WORD_O);
    chk("running", 0, RUNNING_O);
    RST_I = 1'b0;
    repeat (2) @(posedge CLK_I);
    #1 chk_word(w_exp);
    chk("running", 1, RUNNING_O);
    chk("straps", {IFACE_SEL_PIN_I, MODE_SEL_PIN_I},
        {IFACE_SEL_O, MODE_SEL_O});
    strap_exp = {IFACE_SEL_PIN_I, MODE_SEL_PIN_I};
    // Pins flipped after capture: word and straps must not follow them
    {IFACE_SEL_PIN_I, MODE_SEL_PIN_I, NOISE_SUPPRESS_ON_PIN_I,
     COMPAND_LAW_CHOICE_PIN_I, COMPAND_ON_PIN_I, ECHO_SUPPRESS_ON_PIN_I,
     SILENCE_FRAME_ON_PIN_I, ECHO_CANCEL_ON_PIN_I} =
      ~{IFACE_SEL_PIN_I, MODE_SEL_PIN_I, NOISE_SUPPRESS_ON_PIN_I,
        COMPAND_LAW_CHOICE_PIN_I, COMPAND_ON_PIN_I, ECHO_SUPPRESS_ON_PIN_I,
        SILENCE_FRAME_ON_PIN_I, ECHO_CANCEL_ON_PIN_I};
    foreach (sizes[i]) begin
      frame(sizes[i], rnd() & 1);
      chk_word(w_exp);
      drain();
    end
    enc_host_model_i.pkt(0, 1'b1, 1'b0, 16'hFFFF);
    chk_word(16'h7BC0);
    repeat (3) frame(160, 1'b1);
    chk("full", 0, SAMPLE_READY_O);
    drain();
    frame(157, 1'b0);
    chk_word(w_exp);
    drain();
    chk("straps_held", strap_exp, {IFACE_SEL_O, MODE_SEL_O});
    chk("dec_seen", 1, last_dec > 0);
    stop_test();
  end
endmodule : encoder_feature_control_tb
`default_nettype wire
